// File: shared/srl_cfg.svh
// Operation
// - The latch is a level-sensitive set-reset store that changes with no clock edge, with active-high set and reset.
// - The latch can be set or reset by the software pulse bits, comparator one, comparator two, the external pin and the pulse generator.
// - When the combined set and combined reset are both high, reset wins and the latch stays reset.
// - The software set and reset bits clear themselves after acting, so one write completes the operation.
// - Either comparator may be a set or reset source, optionally resampled on the timer clock tick.
// - The external latch input may be routed to set, reset or both.
// - A 3-bit divider field selects a pulse period of 4, 8, 16, 32, 64, 128, 256 or 512 oscillator cycles.
// - Separate enables pass the pulse generator to set and to reset, and a cleared enable removes its effect.
// - True and complementary outputs have independent output enables and may drive their pins together.
// - A latch output drives its pin only while that pin's direction bit is cleared.
// - Device reset does not initialise the latch state.
// - The pulse generator emits one pulse one oscillator cycle wide every N cycles, N the selected divisor.
// - With the latch enable cleared, neither output enable drives any pin.
// - A software set or reset write asserts the latch input for one clock period, and both bits read back as zero.
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

`define SRL_CNT_W        9
`define SRL_CNT_RESET    9'h000
`define SRL_BASE_DIV     9'h004
`define SRL_ONE_CNT      9'h001
`define SRL_SYNC_DEPTH   3
`define SRL_NUM_ASYNC    3
`define SRL_IDX_COMP1    0
`define SRL_IDX_COMP2    1
`define SRL_IDX_PIN      2
`define SRL_ASYNC_RESET  3'h0

`endif

// File: shared/srl_pkg.sv
`default_nettype none
package srl_pkg;

  typedef struct packed {
    logic       latch_enable;
    logic [2:0] pulse_divider_select;
    logic       true_output_enable;
    logic       complement_output_enable;
    logic       software_set_pulse;
    logic       software_reset_pulse;
  } srl_ctrl_type;

  typedef struct packed {
    logic set_from_pin;
    logic pulse_to_set_enable;
    logic set_from_comp_two;
    logic set_from_comp_one;
    logic reset_from_pin;
    logic pulse_to_reset_enable;
    logic reset_from_comp_two;
    logic reset_from_comp_one;
  } srl_source_type;

  typedef struct packed {
    logic data;
    logic oe;
  } srl_pin_type;

endpackage : srl_pkg
`default_nettype wire

// File: verilog/srl_pulse_gen.sv
`include "srl_cfg.svh"
`default_nettype none
module srl_pulse_gen (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clock_en,
  input  wire logic       run,
  input  wire logic [2:0] pulse_divider_select,
  output var  logic       pulse
);
  import srl_pkg::*;

  logic [`SRL_CNT_W-1:0] count_r;
  logic [`SRL_CNT_W-1:0] count_nxt;
  logic [`SRL_CNT_W-1:0] mask;
  logic                  terminal;
  logic                  pulse_r;

  // ----------------------------------------------------------------
  // Period select
  // ----------------------------------------------------------------
  // The terminal test looks only at the low bits, so a new divisor acts at once,
  // never later than the next terminal count.
  assign mask      = (`SRL_BASE_DIV << pulse_divider_select) - `SRL_ONE_CNT;
  assign terminal  = run && ((count_r & mask) == mask);
  assign count_nxt = count_r + `SRL_ONE_CNT;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= `SRL_CNT_RESET;
    end else if (clock_en && run) begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pulse_r <= 1'b0;
    end else if (clock_en) begin
      pulse_r <= terminal;
    end
  end

  assign pulse = pulse_r;

endmodule : srl_pulse_gen
`default_nettype wire

// File: verilog/srl_top.sv
`include "srl_cfg.svh"
`default_nettype none
module srl_top (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                clock_en,
  input  wire srl_pkg::srl_ctrl_type   ctrl,
  input  wire logic                ctrl_write,
  input  wire srl_pkg::srl_source_type src,
  input  wire logic                comp_timer_sync_enable,
  input  wire logic                timer_clock_tick,
  input  wire logic                comparator_one_out,
  input  wire logic                comparator_two_out,
  input  wire logic                external_latch_input,
  input  wire logic                pin_direction_bit_true,
  input  wire logic                pin_direction_bit_complement,
  output var  srl_pkg::srl_pin_type    true_output_pin,
  output var  srl_pkg::srl_pin_type    complement_output_pin,
  output var  srl_pkg::srl_ctrl_type   ctrl_readback,
  output var  logic                latch_state
);
  import srl_pkg::*;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  srl_ctrl_type ctrl_r;
  logic         sw_set_r;
  logic         sw_reset_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= '0;
    end else if (clock_en && ctrl_write) begin
      ctrl_r                      <= ctrl;
      ctrl_r.software_set_pulse   <= 1'b0;
      ctrl_r.software_reset_pulse <= 1'b0;
    end
  end

  // Each strobe lives one clock only, so one write is a whole operation.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sw_set_r <= 1'b0;
    end else if (clock_en) begin
      sw_set_r <= ctrl_write && ctrl.software_set_pulse;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sw_reset_r <= 1'b0;
    end else if (clock_en) begin
      sw_reset_r <= ctrl_write && ctrl.software_reset_pulse;
    end
  end

  assign ctrl_readback = ctrl_r;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // A level is accepted only when the second and third stages agree, which
  // costs a cycle of delay but rejects a single metastable sample.
  logic [`SRL_NUM_ASYNC-1:0] async_in;
  logic [`SRL_NUM_ASYNC-1:0] sync_a_r;
  logic [`SRL_NUM_ASYNC-1:0] sync_b_r;
  logic [`SRL_NUM_ASYNC-1:0] sync_c_r;
  logic [`SRL_NUM_ASYNC-1:0] clean_r;

  assign async_in[`SRL_IDX_COMP1] = comparator_one_out;
  assign async_in[`SRL_IDX_COMP2] = comparator_two_out;
  assign async_in[`SRL_IDX_PIN]   = external_latch_input;

  genvar g;
  generate
    for (g = 0; g < `SRL_NUM_ASYNC; g = g + 1) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          sync_a_r[g] <= 1'b0;
          sync_b_r[g] <= 1'b0;
          sync_c_r[g] <= 1'b0;
        end else if (clock_en) begin
          sync_a_r[g] <= async_in[g];
          sync_b_r[g] <= sync_a_r[g];
          sync_c_r[g] <= sync_b_r[g];
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          clean_r[g] <= 1'b0;
        end else if (clock_en && (sync_b_r[g] == sync_c_r[g])) begin
          clean_r[g] <= sync_c_r[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Comparator resampling
  // ----------------------------------------------------------------
  logic comparator_one_synced_out;
  logic comparator_two_synced_out;
  logic comp_one_held_r;
  logic comp_two_held_r;

  // With comp_timer_sync_enable set, the comparator levels are resampled on the timer tick and held between ticks; otherwise they follow directly.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      comp_one_held_r <= 1'b0;
      comp_two_held_r <= 1'b0;
    end else if (clock_en && timer_clock_tick) begin
      comp_one_held_r <= clean_r[`SRL_IDX_COMP1];
      comp_two_held_r <= clean_r[`SRL_IDX_COMP2];
    end
  end

  assign comparator_one_synced_out = comp_timer_sync_enable ? comp_one_held_r
                                                            : clean_r[`SRL_IDX_COMP1];
  assign comparator_two_synced_out = comp_timer_sync_enable ? comp_two_held_r
                                                            : clean_r[`SRL_IDX_COMP2];

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  logic gen_pulse;

  srl_pulse_gen u_pulse_gen (
    .clock                (clock),
    .rst_n                (rst_n),
    .clock_en             (clock_en),
    .run                  (ctrl_r.latch_enable),
    .pulse_divider_select (ctrl_r.pulse_divider_select),
    .pulse                (gen_pulse)
  );

  // ----------------------------------------------------------------
  // Source combination
  // ----------------------------------------------------------------
  logic set_in;
  logic reset_in;

  assign set_in = sw_set_r
                | (src.set_from_comp_one     && comparator_one_synced_out)
                | (src.set_from_comp_two     && comparator_two_synced_out)
                | (src.set_from_pin          && clean_r[`SRL_IDX_PIN])
                | (src.pulse_to_set_enable   && gen_pulse);

  assign reset_in = sw_reset_r
                  | (src.reset_from_comp_one   && comparator_one_synced_out)
                  | (src.reset_from_comp_two   && comparator_two_synced_out)
                  | (src.reset_from_pin        && clean_r[`SRL_IDX_PIN])
                  | (src.pulse_to_reset_enable && gen_pulse);

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  // No reset on purpose: software must place the latch before using an output.
  logic latch_q;

  always_latch begin
    if (set_in || reset_in) begin
      latch_q = !reset_in;
    end
  end

  assign latch_state = latch_q;

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  assign true_output_pin.data       = latch_q;
  assign complement_output_pin.data = !latch_q;
  assign true_output_pin.oe         = ctrl_r.latch_enable && ctrl_r.true_output_enable
                                      && !pin_direction_bit_true;
  assign complement_output_pin.oe   = ctrl_r.latch_enable && ctrl_r.complement_output_enable
                                      && !pin_direction_bit_complement;

endmodule : srl_top
`default_nettype wire

// File: tb/srl_partner.sv
`default_nettype none
module srl_partner (
  input  wire logic [2:0] drive_req,
  output wire logic       comparator_one_out,
  output wire logic       comparator_two_out,
  output wire logic       external_latch_input
);
  // --------------------------------
  // Comparators and external pin
  // --------------------------------
  // Levels move off the clock edge, so the synchroniser sees real skew.
  assign #7 comparator_one_out   = drive_req[0];
  assign #7 comparator_two_out   = drive_req[1];
  assign #7 external_latch_input = drive_req[2];
endmodule : srl_partner
`default_nettype wire

// File: tb/srl_top_assertions.sv
`default_nettype none
module srl_top_assertions (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    clock_en,
  input wire srl_pkg::srl_ctrl_type   ctrl,
  input wire logic                    ctrl_write,
  input wire srl_pkg::srl_source_type src,
  input wire logic                    pin_direction_bit_true,
  input wire logic                    pin_direction_bit_complement,
  input wire srl_pkg::srl_pin_type    true_output_pin,
  input wire srl_pkg::srl_pin_type    complement_output_pin,
  input wire srl_pkg::srl_ctrl_type   ctrl_readback,
  input wire logic                    latch_state
);
  import srl_pkg::*;
  // --------------------------------
  // Port relations
  // --------------------------------
  logic wr_take;
  assign wr_take = ctrl_write & clock_en;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rb;
    logic [7:0] v;
    (wr_take, v = ctrl) |=> ctrl_readback == {v[7:2], 2'h0};
  endproperty
  pulse_bits_zero_a: assert property (ctrl_readback[1:0] == 2'h0) else $error("pulse bits read set");
  readback_load_a: assert property (p_rb) else $error("readback wrong");
  oe_true_a: assert property (true_output_pin.oe == (ctrl_readback.latch_enable
    & ctrl_readback.true_output_enable & !pin_direction_bit_true)) else $error("true oe wrong");
  oe_comp_a: assert property (complement_output_pin.oe == (ctrl_readback.latch_enable
    & ctrl_readback.complement_output_enable & !pin_direction_bit_complement)) else $error("comp oe wrong");
  pin_data_a: assert property (true_output_pin.oe |-> true_output_pin.data == latch_state
    && complement_output_pin.data == !latch_state) else $error("pin data wrong");
  sw_set_a: assert property (wr_take && ctrl[1:0] == 2'h2 && src == 8'h00 |=> latch_state) else $error("no set");
  sw_reset_a: assert property (wr_take && ctrl[1:0] == 2'h1 |=> !latch_state) else $error("no reset");
  reset_wins_a: assert property (wr_take && ctrl[1:0] == 2'h3 && src == 8'h00 |=> !latch_state [*2])
    else $error("set won");
  quiet_hold_a: assert property ((src == 8'h00 && !wr_take) ##1 src == 8'h00 |-> $stable(latch_state))
    else $error("latch moved");
  cover property (wr_take && ctrl[1:0] == 2'h3);
  cover property (true_output_pin.oe && complement_output_pin.oe);
  cover property ($rose(latch_state) && src.pulse_to_set_enable);
endmodule : srl_top_assertions
bind srl_top srl_top_assertions chk_u (.clock, .rst_n, .clock_en, .ctrl, .ctrl_write, .src, .pin_direction_bit_true,
  .pin_direction_bit_complement, .true_output_pin, .complement_output_pin, .ctrl_readback, .latch_state);
`default_nettype wire

// File: tb/srl_top_bench.sv
`default_nettype none
module srl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import srl_pkg::*;
  // --------------------------------
  // Stimulus and checks
  // --------------------------------
  logic           clock = 1'b0;
  logic           rst_n = 1'b0;
  logic           clock_en = 1'b1;
  logic           ctrl_write = 1'b0;
  logic           sync_en = 1'b0;
  logic           tick = 1'b0;
  logic           dir_t = 1'b0;
  logic           dir_c = 1'b0;
  logic [2:0]     drv = 3'h0;
  srl_ctrl_type   ctrl = 8'h00;
  srl_source_type src = 8'h00;
  srl_pin_type    q_pin, nq_pin;
  srl_ctrl_type   rb;
  logic           latch_q, cmp1, cmp2, ext_in;
  int             num_errors = 0;
  int             n_tests = 0;
  int             cyc = 0;
  int             n, t0;
  always #50 clock = ~clock;
  always @(negedge clock) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 0);
  end
  srl_partner far_u (.drive_req(drv), .comparator_one_out(cmp1), .comparator_two_out(cmp2),
    .external_latch_input(ext_in));
  srl_top dut_u (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .ctrl(ctrl), .ctrl_write(ctrl_write),
    .src(src), .comp_timer_sync_enable(sync_en), .timer_clock_tick(tick), .comparator_one_out(cmp1),
    .comparator_two_out(cmp2), .external_latch_input(ext_in), .pin_direction_bit_true(dir_t),
    .pin_direction_bit_complement(dir_c), .true_output_pin(q_pin), .complement_output_pin(nq_pin),
    .ctrl_readback(rb), .latch_state(latch_q));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] v);
    @(negedge clock);
    ctrl = v;
    ctrl_write = 1'b1;
    @(negedge clock);
    ctrl_write = 1'b0;
  endtask : wr
  task automatic wait_q(input logic v, input int lim);
    n = 0;
    while (latch_q !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    check(16'(latch_q), 16'(v));
  endtask : wait_q
  task automatic test_sw;
    check(16'({rb, q_pin.oe, nq_pin.oe}), 16'h0000);
    wr(8'h02);
    wait_q(1'b1, 0);
    check(16'(rb), 16'h0000);
    wr(8'h03);
    wait_q(1'b0, 0);
    @(negedge clock);
    clock_en = 1'b0;
    wr(8'hF2);
    wait_q(1'b0, 0);
    check(16'(rb), 16'h0000);
    clock_en = 1'b1;
  endtask : test_sw
  task automatic test_oe;
    for (int k = 0; k < 16; k++) begin
      dir_t = k[0];
      dir_c = k[0];
      wr({k[3], 3'h0, k[2], k[1], 2'h0});
      check(16'(rb), 16'({k[3], 3'h0, k[2], k[1], 2'h0}));
      check(16'({q_pin.oe, nq_pin.oe}), 16'({k[3] & k[2] & !k[0], k[3] & k[1] & !k[0]}));
      check(16'({q_pin.data, nq_pin.data}), 16'h0001);
    end
  endtask : test_oe
  task automatic test_async;
    int sb[3] = '{4, 5, 7};
    int rs[3] = '{0, 1, 3};
    for (int i = 0; i < 3; i++) begin
      sync_en = (i == 1);
      src = 8'h00;
      src[sb[i]] = 1'b1;
      drv[i] = 1'b1;
      wait_q(1'b1, 12);
      drv[i] = 1'b0;
      repeat (8) @(negedge clock);
      src = 8'h00;
      src[rs[i]] = 1'b1;
      drv[i] = 1'b1;
      wait_q(1'b0, 12);
      drv[i] = 1'b0;
      repeat (8) @(negedge clock);
    end
    wr(8'h8E);
    wait_q(1'b1, 0);
    src = 8'h88;
    drv = 3'h4;
    repeat (8) @(negedge clock);
    wait_q(1'b0, 0);
    drv = 3'h0;
    src = 8'h00;
  endtask : test_async
  task automatic test_pulse;
    for (int s = 0; s < 8; s++) begin
      src = 8'h00;
      wr({1'b1, s[2:0], 4'h1});
      src = 8'h40;
      wait_q(1'b1, (8 << s) + 8);
      t0 = cyc;
      wr({1'b1, s[2:0], 4'h1});
      wait_q(1'b1, (4 << s) + 8);
      check(16'(cyc - t0), 16'(4 << s));
    end
    src = 8'h04;
    wait_q(1'b0, 600);
    src = 8'h00;
    wr(8'hF2);
    repeat (1100) @(negedge clock);
    wait_q(1'b1, 0);
  endtask : test_pulse
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    test_sw();
    test_oe();
    test_async();
    test_pulse();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
endmodule : srl_top_bench
`default_nettype wire
